// File: stamp_pkg.sv
// Constants, register indices and field layout of the video timestamp capture unit
package stamp_pkg;

  // ==========================================================================
  // Clock and tick periods
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TICK0_NS      = 40;
  localparam int unsigned TICK1_NS      = 80;
  localparam int unsigned TICK2_NS      = 160;
  localparam int unsigned TICK3_NS      = 1000;
  localparam int unsigned TICK0_CYC     = TICK0_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK1_CYC     = TICK1_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK2_CYC     = TICK2_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK3_CYC     = TICK3_NS / CLK_PERIOD_NS;
  localparam int unsigned DIV_W         = 7;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_CONFIG    = 8'h25;
  localparam logic [7:0] IDX_CONTROL   = 8'h26;
  localparam logic [7:0] IDX_LINE_HIGH = 8'h27;
  localparam logic [7:0] IDX_LINE_LOW  = 8'h28;
  localparam logic [7:0] IDX_STATE     = 8'h29;
  localparam logic [7:0] IDX_P0_HIGH   = 8'h2a;
  localparam logic [7:0] IDX_P0_LOW    = 8'h2b;
  localparam logic [7:0] IDX_P1_HIGH   = 8'h2c;
  localparam logic [7:0] IDX_P1_LOW    = 8'h2d;
  localparam logic [7:0] IDX_RSVD_FIRST = 8'h2e;
  localparam logic [7:0] IDX_RSVD_LAST  = 8'h32;
  localparam logic [7:0] IDX_IRQ_STATE = 8'h38;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'h39;

  // ==========================================================================
  // Field positions and writable masks
  localparam int unsigned CFG_EVENT_BIT  = 0;
  localparam int unsigned CFG_FREE_BIT   = 1;
  localparam int unsigned CFG_EARLY_BIT  = 3;
  localparam int unsigned CFG_TICK_LSB   = 4;
  localparam int unsigned CFG_EDGE_BIT   = 6;
  localparam int unsigned CTL_HOLD_BIT   = 4;
  localparam int unsigned STATE_RDY_BIT  = 4;
  localparam logic [7:0]  CFG_WMASK      = 8'h7b;
  localparam logic [7:0]  CTL_WMASK      = 8'h13;
  localparam logic [7:0]  RESET_BYTE     = 8'h00;

  // Interrupt bits: port 0 capture, port 1 capture, stamps ready
  localparam int unsigned IRQ_W          = 3;
  localparam int unsigned IRQ_READY_BIT  = 2;
  localparam logic [IRQ_W-1:0] IRQ_WMASK = 3'h7;

  typedef enum logic [1:0] {TICK_40NS, TICK_80NS, TICK_160NS, TICK_1US} tick_sel_t;

endpackage : stamp_pkg

// File: video_timestamp_capture.sv
// Video timestamp capture unit with APB register bank and interrupt
//
// Local design decision: register access over APB.
`timescale 1ns/1ns

module video_timestamp_capture
  import stamp_pkg::*;
#(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned PORTS  = 2,
  parameter int unsigned STAMP_W = 16
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Video timing
  input  wire logic              frameStrobe,
  input  wire logic [PORTS-1:0]  rxFrameStart,
  input  wire logic [PORTS-1:0]  rxLineStart,
  // Interrupt
  output logic                   irq
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0]                    stampConfig;
    logic [7:0]                    stampControl;
    logic [7:0]                    targetLineUpper;
    logic [7:0]                    targetLineLower;
    logic [PORTS-1:0][STAMP_W-1:0] stamp;
    logic [PORTS-1:0][STAMP_W-1:0] lineCount;
    logic [PORTS-1:0]              armed;
    logic [PORTS-1:0]              stampValid;
    logic                          stampsReady;
    logic                          readyPending;
    logic [STAMP_W-1:0]            counter;
    logic [DIV_W-1:0]              divider;
    logic                          strobePrev;
    logic [IRQ_W-1:0]              irqState;
    logic [IRQ_W-1:0]              irqMask;
    logic [31:0]                   readData;
  } state_t;

  state_t state_q;
  state_t state_d;

  logic [7:0]               regIndex;
  logic                     setupPhase;
  logic                     writeAccess;
  logic                     strobeEdge;
  logic                     tick;
  logic [DIV_W-1:0]         tickLast;
  logic [STAMP_W-1:0]       targetLine;
  logic [PORTS-1:0]         enables;
  logic [PORTS-1:0]         capture;
  logic [PORTS-1:0]         atTarget;
  logic                     holdOn;
  logic                     holdSet;
  logic                     holdRelease;
  logic                     allValid;
  logic [IRQ_W-1:0]         irqEvents;
  logic [STAMP_W-1:0]       nextLine [PORTS];

  // ==========================================================================
  // Decode and derived control
  assign regIndex    = paddr[9:2];
  assign setupPhase  = psel && !penable;
  assign writeAccess = psel && penable && pwrite;
  assign targetLine  = {state_q.targetLineUpper, state_q.targetLineLower};
  assign enables     = state_q.stampControl[PORTS-1:0];
  assign holdOn      = state_q.stampControl[CTL_HOLD_BIT];
  assign holdSet     = writeAccess && (regIndex == IDX_CONTROL) && pwdata[CTL_HOLD_BIT];
  assign holdRelease = writeAccess && (regIndex == IDX_CONTROL) && holdOn
                       && !pwdata[CTL_HOLD_BIT];

  // Active strobe edge by polarity bit
  assign strobeEdge = state_q.stampConfig[CFG_EDGE_BIT] ?
                      (state_q.strobePrev && !frameStrobe) :
                      (!state_q.strobePrev && frameStrobe);

  // Tick period by resolution code
  always_comb begin
    case (tick_sel_t'(state_q.stampConfig[CFG_TICK_LSB +: 2]))
      TICK_40NS:  tickLast = DIV_W'(TICK0_CYC - 1);
      TICK_80NS:  tickLast = DIV_W'(TICK1_CYC - 1);
      TICK_160NS: tickLast = DIV_W'(TICK2_CYC - 1);
      default:    tickLast = DIV_W'(TICK3_CYC - 1);
    endcase
  end
  assign tick = (state_q.divider >= tickLast);

  // Per-port capture decision
  always_comb begin
    for (int i = 0; i < PORTS; i++) begin
      nextLine[i] = state_q.lineCount[i] + 16'h0001;
      atTarget[i] = rxLineStart[i] && (nextLine[i] == targetLine);
      if (!state_q.stampConfig[CFG_EVENT_BIT]) begin
        capture[i] = enables[i] && !holdOn && atTarget[i];
      end else if (state_q.stampConfig[CFG_FREE_BIT]) begin
        capture[i] = enables[i] && !holdOn && rxFrameStart[i] && state_q.armed[i];
      end else begin
        capture[i] = enables[i] && !holdOn && rxFrameStart[i];
      end
    end
  end

  // ==========================================================================
  // Next state
  always_comb begin
    state_d = state_q;
    state_d.strobePrev = frameStrobe;

    // Counter: resolution divider, strobe sync in frame-sync mode
    if (!state_q.stampConfig[CFG_FREE_BIT] && strobeEdge) begin
      state_d.counter = '0;
      state_d.divider = '0;
    end else if (tick) begin
      state_d.counter = state_q.counter + 16'h0001;
      state_d.divider = '0;
    end else begin
      state_d.divider = state_q.divider + 7'h01;
    end

    // Line tracking, arming and capture
    for (int i = 0; i < PORTS; i++) begin
      if (rxFrameStart[i]) begin
        state_d.lineCount[i] = '0;
        state_d.armed[i] = 1'b0;
      end else if (rxLineStart[i]) begin
        state_d.lineCount[i] = nextLine[i];
        if (atTarget[i]) begin
          state_d.armed[i] = 1'b1;
        end
      end
      if (capture[i]) begin
        state_d.stamp[i] = state_q.counter;
        state_d.stampValid[i] = 1'b1;
      end
    end

    // Ready flag
    allValid = (enables != '0) && ((state_d.stampValid & enables) == enables);
    if (holdSet || holdOn) begin
      state_d.stampsReady = 1'b0;
      state_d.readyPending = 1'b0;
    end else if (allValid && (state_q.stampConfig[CFG_EARLY_BIT]
                 || state_q.stampConfig[CFG_FREE_BIT])) begin
      state_d.stampsReady = 1'b1;
    end else if (allValid) begin
      state_d.readyPending = 1'b1;
      if (state_q.readyPending && strobeEdge) begin
        state_d.stampsReady = 1'b1;
      end
    end
    if (holdRelease) begin
      state_d.stampValid = '0;
      state_d.readyPending = 1'b0;
    end

    // Register writes
    if (writeAccess) begin
      if (regIndex == IDX_CONFIG) begin
        state_d.stampConfig = pwdata[7:0] & CFG_WMASK;
      end else if (regIndex == IDX_CONTROL) begin
        state_d.stampControl = pwdata[7:0] & CTL_WMASK;
      end else if (regIndex == IDX_LINE_HIGH) begin
        state_d.targetLineUpper = pwdata[7:0];
      end else if (regIndex == IDX_LINE_LOW) begin
        state_d.targetLineLower = pwdata[7:0];
      end else if (regIndex == IDX_IRQ_MASK) begin
        state_d.irqMask = pwdata[IRQ_W-1:0] & IRQ_WMASK;
      end
    end

    // Interrupt status: clear by writing one, a new event wins
    irqEvents = {state_d.stampsReady && !state_q.stampsReady, capture};
    if (writeAccess && (regIndex == IDX_IRQ_STATE)) begin
      state_d.irqState = state_q.irqState & ~pwdata[IRQ_W-1:0];
    end
    state_d.irqState = state_d.irqState | irqEvents;

    // Read data captured in the setup phase
    if (setupPhase && !pwrite) begin
      state_d.readData = '0;
      if (regIndex == IDX_CONFIG) begin
        state_d.readData[7:0] = state_q.stampConfig;
      end else if (regIndex == IDX_CONTROL) begin
        state_d.readData[7:0] = state_q.stampControl;
      end else if (regIndex == IDX_LINE_HIGH) begin
        state_d.readData[7:0] = state_q.targetLineUpper;
      end else if (regIndex == IDX_LINE_LOW) begin
        state_d.readData[7:0] = state_q.targetLineLower;
      end else if (regIndex == IDX_STATE) begin
        state_d.readData[STATE_RDY_BIT] = state_q.stampsReady;
        state_d.readData[PORTS-1:0] = state_q.stampValid;
      end else if (regIndex == IDX_P0_HIGH) begin
        state_d.readData[7:0] = state_q.stamp[0][15:8];
      end else if (regIndex == IDX_P0_LOW) begin
        state_d.readData[7:0] = state_q.stamp[0][7:0];
      end else if (regIndex == IDX_P1_HIGH) begin
        state_d.readData[7:0] = state_q.stamp[1][15:8];
      end else if (regIndex == IDX_P1_LOW) begin
        state_d.readData[7:0] = state_q.stamp[1][7:0];
      end else if (regIndex == IDX_IRQ_STATE) begin
        state_d.readData[IRQ_W-1:0] = state_q.irqState;
      end else if (regIndex == IDX_IRQ_MASK) begin
        state_d.readData[IRQ_W-1:0] = state_q.irqMask;
      end else begin
        state_d.readData = '0;
      end
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata  = state_q.readData;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign irq     = |(state_q.irqState & state_q.irqMask);

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_hold_freezes: assert property (
    holdOn |=> ($stable(state_q.stamp[0]) && $stable(state_q.stamp[1])))
    else $error("stamps changed while held");

  a_hold_clears_ready: assert property (
    holdSet |=> !state_q.stampsReady [*2])
    else $error("ready not cleared by hold");

  a_disabled_port: assert property (
    !enables[0] |=> $stable(state_q.stamp[0]))
    else $error("disabled port captured");

  a_capture_copies: assert property (
    capture[1] |=> (state_q.stamp[1] == $past(state_q.counter)) && state_q.stampValid[1])
    else $error("capture did not copy counter");

  a_counter_step: assert property (
    (tick && !(strobeEdge && !state_q.stampConfig[CFG_FREE_BIT]))
    |=> state_q.counter == 16'($past(state_q.counter) + 16'h0001))
    else $error("counter did not advance");

  a_counter_idle: assert property (
    (!tick && !strobeEdge) |=> $stable(state_q.counter))
    else $error("counter moved between ticks");

  a_tick_40ns: assert property (
    (tick && state_q.stampConfig[5:4] == 2'h0 && !strobeEdge)
    ##1 (state_q.stampConfig[5:4] == 2'h0 && !strobeEdge) [*5]
    |-> tick)
    else $error("40 ns tick period wrong");

  a_strobe_sync: assert property (
    (strobeEdge && !state_q.stampConfig[CFG_FREE_BIT]) |=> state_q.counter == '0)
    else $error("strobe did not sync counter");

  a_line_target: assert property (
    (capture[0] && !state_q.stampConfig[CFG_EVENT_BIT]) |-> nextLine[0] == targetLine)
    else $error("line capture off target");

  a_early_ready: assert property (
    (state_q.stampConfig[CFG_EARLY_BIT] && !holdOn && !holdSet && allValid)
    |=> state_q.stampsReady)
    else $error("early ready missing");

  a_state_read: assert property (
    (setupPhase && !pwrite && regIndex == IDX_STATE)
    |=> prdata == {27'h0, $past(state_q.stampsReady), 2'h0, $past(state_q.stampValid)})
    else $error("status read wrong");

  a_reserved_zero: assert property (
    (setupPhase && !pwrite && regIndex >= IDX_RSVD_FIRST && regIndex <= IDX_RSVD_LAST)
    |=> prdata == 32'h0)
    else $error("reserved read not zero");

  a_ready_event: assert property (
    $rose(state_q.stampsReady) |-> state_q.irqState[IRQ_READY_BIT])
    else $error("ready event not flagged");

  a_irq_set_wins: assert property (
    capture[0] |=> state_q.irqState[0])
    else $error("event lost on clear");

  a_reset_values: assert property (
    $rose(resetn) |-> (state_q.stampControl == RESET_BYTE) && !state_q.stampsReady)
    else $error("reset values wrong");

  a_rising_edge: assert property (
    (!state_q.stampConfig[CFG_EDGE_BIT] && $rose(frameStrobe)) |-> strobeEdge)
    else $error("rising strobe edge missed");

  a_falling_edge: assert property (
    (state_q.stampConfig[CFG_EDGE_BIT] && $fell(frameStrobe)) |-> strobeEdge)
    else $error("falling strobe edge missed");

  a_ready_needs_strobe: assert property (
    ($rose(state_q.stampsReady) && !$past(state_q.stampConfig[CFG_EARLY_BIT])
     && !$past(state_q.stampConfig[CFG_FREE_BIT])) |-> $past(strobeEdge))
    else $error("normal ready without strobe");

  a_release_clears: assert property (
    holdRelease |=> (state_q.stampValid == '0))
    else $error("valid flags kept after release");

  a_line_count: assert property (
    (rxLineStart[0] && !rxFrameStart[0]) |=> state_q.lineCount[0] == $past(nextLine[0]))
    else $error("line count did not advance");

  a_frame_clears: assert property (
    rxFrameStart[0] |=> (state_q.lineCount[0] == '0) && !state_q.armed[0])
    else $error("frame start did not clear line state");

  a_unarmed_frame: assert property (
    (rxFrameStart[1] && !state_q.armed[1] && state_q.stampConfig[CFG_EVENT_BIT]
     && state_q.stampConfig[CFG_FREE_BIT]) |=> $stable(state_q.stamp[1]))
    else $error("unarmed frame start captured");

  c_line_capture: cover property (
    capture[0] && !state_q.stampConfig[CFG_EVENT_BIT]);

  c_frame_freerun: cover property (
    capture[1] && state_q.stampConfig[CFG_EVENT_BIT] && state_q.stampConfig[CFG_FREE_BIT]);

  c_ready_rise: cover property (
    $rose(state_q.stampsReady));

  c_hold_cycle: cover property (
    holdSet ##[1:50] holdRelease);

endmodule : video_timestamp_capture

// File: tb_video_timestamp_capture.sv
// Self-checking testbench for the video timestamp capture unit
`timescale 1ns/1ns

module tb_video_timestamp_capture
  import stamp_pkg::*;
;
  // ==========================================================================
  // Signals and model state
  localparam int CYC_LIMIT = 20000;
  logic        clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        frameStrobe;
  logic [1:0]  rxFrameStart;
  logic [1:0]  rxLineStart;
  logic        irq;
  logic [31:0] rd;
  int          failCount = 0;
  int          nTests    = 0;
  int          cyc       = 0;
  int          t0        = 0;
  int          expStamp [2];
  int          divs     [4] = '{TICK0_CYC, TICK1_CYC, TICK2_CYC, TICK3_CYC};

  video_timestamp_capture u_dut (
    .clk          (clk),
    .resetn       (resetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .frameStrobe  (frameStrobe),
    .rxFrameStart (rxFrameStart),
    .rxLineStart  (rxLineStart),
    .irq          (irq)
  );

  // ==========================================================================
  // Clock, cycle count and timeout
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == CYC_LIMIT) begin
      failCount++;
      $display("BAD t=%0t run took too long", $time);
      summarize();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    nTests++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    check({31'h0, pslverr}, 32'h0, "slave error");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask : wr

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input string what);
    apb(1'b0, idx, 32'h0);
    check(rd, exp, what);
  endtask : rdchk

  task automatic checkStamps();
    rdchk(IDX_P0_HIGH, {24'h0, expStamp[0][15:8]}, "port0 upper");
    rdchk(IDX_P0_LOW, {24'h0, expStamp[0][7:0]}, "port0 lower");
    rdchk(IDX_P1_HIGH, {24'h0, expStamp[1][15:8]}, "port1 upper");
    rdchk(IDX_P1_LOW, {24'h0, expStamp[1][7:0]}, "port1 lower");
  endtask : checkStamps

  task automatic strobeEdge(input logic pol);
    @(posedge clk);
    frameStrobe <= pol;
    repeat (3) @(posedge clk);
    frameStrobe <= ~pol;
    t0 = cyc;
  endtask : strobeEdge

  task automatic pulseAt(input int t, input logic [1:0] fs, input logic [1:0] ls);
    while (cyc - t0 < t) @(posedge clk);
    rxFrameStart <= fs;
    rxLineStart  <= ls;
    @(posedge clk);
    rxFrameStart <= 2'b00;
    rxLineStart  <= 2'b00;
  endtask : pulseAt

  // ==========================================================================
  // Main sequence
  initial begin
    int          n;
    int          m0;
    int          m1;
    logic [15:0] tgt;
    logic [31:0] r;
    resetn       = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 12'h000;
    pwdata       = 32'h0;
    frameStrobe  = 1'b0;
    rxFrameStart = 2'b00;
    rxLineStart  = 2'b00;
    void'($urandom(32'h02cb5aff));
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    check({30'h0, pready, irq}, 32'h2, "idle outputs");
    for (int i = 'h25; i <= 'h32; i++) rdchk(i[7:0], 32'h0, "reset value");
    rdchk(IDX_IRQ_STATE, 32'h0, "irq state reset");
    rdchk(8'h40, 32'h0, "unmapped read");
    $display("test reset values done");
    r = $urandom();
    wr(IDX_CONFIG, r);
    rdchk(IDX_CONFIG, r & {24'h0, CFG_WMASK}, "config rw");
    r = $urandom();
    wr(IDX_CONTROL, r);
    rdchk(IDX_CONTROL, r & {24'h0, CTL_WMASK}, "control rw");
    r = $urandom();
    wr(IDX_LINE_HIGH, r);
    rdchk(IDX_LINE_HIGH, {24'h0, r[7:0]}, "line upper rw");
    wr(IDX_LINE_LOW, ~r);
    rdchk(IDX_LINE_LOW, {24'h0, ~r[7:0]}, "line lower rw");
    wr(IDX_IRQ_MASK, r);
    rdchk(IDX_IRQ_MASK, {29'h0, r[2:0]}, "mask rw");
    for (int i = 'h29; i <= 'h32; i++) begin
      wr(i[7:0], 32'hff);
      rdchk(i[7:0], 32'h0, "read-only write");
    end
    $display("test register access done");
    for (int c = 0; c < 4; c++) begin
      n = divs[c];
      wr(IDX_CONFIG, {24'h0, 1'b0, c[0], c[1:0], 4'h1});
      wr(IDX_CONTROL, 32'h03);
      wr(IDX_IRQ_MASK, 32'h4);
      wr(IDX_IRQ_STATE, 32'h7);
      strobeEdge(c[0]);
      while (cyc - t0 < n / 2 + 1) @(posedge clk);
      frameStrobe <= c[0];
      m0 = 1 + $urandom % 3;
      m1 = m0 + 1 + $urandom % 2;
      pulseAt(n * m0 + n / 2 + 1, 2'b01, 2'b00);
      pulseAt(n * m1 + n / 2 + 1, 2'b10, 2'b00);
      expStamp[0] = m0;
      expStamp[1] = m1;
      rdchk(IDX_STATE, 32'h03, "valid before ready");
      check({31'h0, irq}, 32'h0, "masked irq");
      strobeEdge(c[0]);
      repeat (3) @(posedge clk);
      rdchk(IDX_STATE, 32'h13, "ready after strobe");
      check({31'h0, irq}, 32'h1, "ready irq");
      rdchk(IDX_IRQ_STATE, 32'h7, "irq state");
      wr(IDX_IRQ_STATE, 32'h7);
      @(posedge clk);
      check({31'h0, irq}, 32'h0, "irq cleared");
      wr(IDX_CONTROL, 32'h13);
      rdchk(IDX_STATE, 32'h03, "hold clears ready");
      pulseAt(0, 2'b11, 2'b00);
      checkStamps();
      wr(IDX_CONTROL, 32'h03);
      rdchk(IDX_STATE, 32'h00, "release clears valid");
      $display("test tick code %0d done", c);
    end
    wr(IDX_CONFIG, 32'h09);
    wr(IDX_CONTROL, 32'h01);
    strobeEdge(1'b0);
    pulseAt(13, 2'b11, 2'b00);
    expStamp[0] = 2;
    rdchk(IDX_STATE, 32'h11, "early ready one port");
    checkStamps();
    wr(IDX_CONTROL, 32'h11);
    wr(IDX_CONTROL, 32'h01);
    $display("test early ready done");
    tgt = 16'h0100 + 16'(2 + $urandom % 60);
    wr(IDX_CONFIG, 32'h00);
    wr(IDX_CONTROL, 32'h03);
    wr(IDX_LINE_HIGH, {24'h0, tgt[15:8]});
    wr(IDX_LINE_LOW, {24'h0, tgt[7:0]});
    strobeEdge(1'b0);
    pulseAt(3, 2'b11, 2'b00);
    for (int l = 1; l <= int'(tgt) + 1; l++) pulseAt(5 * l + 3, 2'b00, 2'b11);
    expStamp[0] = tgt;
    expStamp[1] = tgt;
    rdchk(IDX_STATE, 32'h03, "line capture valid");
    checkStamps();
    wr(IDX_CONTROL, 32'h13);
    wr(IDX_CONTROL, 32'h03);
    $display("test line start done");
    wr(IDX_CONFIG, 32'h03);
    wr(IDX_LINE_HIGH, 32'h0);
    wr(IDX_LINE_LOW, 32'h3);
    t0 = cyc;
    pulseAt(2, 2'b11, 2'b00);
    wr(IDX_CONTROL, 32'h13);
    wr(IDX_CONTROL, 32'h03);
    t0 = cyc;
    pulseAt(3, 2'b11, 2'b00);
    pulseAt(6, 2'b00, 2'b11);
    pulseAt(9, 2'b00, 2'b11);
    pulseAt(12, 2'b11, 2'b00);
    rdchk(IDX_STATE, 32'h00, "not armed");
    t0 = cyc;
    for (int l = 1; l <= 3; l++) pulseAt(3 * l, 2'b00, 2'b11);
    pulseAt(12, 2'b11, 2'b00);
    rdchk(IDX_STATE, 32'h13, "armed capture");
    $display("test free run done");
    summarize();
  end

endmodule : tb_video_timestamp_capture
